// ---- rtl/sram_consts.svh ----
`ifndef SRAM_CONSTS_SVH
`define SRAM_CONSTS_SVH

// ****************************************************************
// Array shape
// ****************************************************************
`define SRAM_ADDR_W        19
`define SRAM_HALF_W        32
`define SRAM_HALVES        2

// ****************************************************************
// Pipeline timing, in rising edges after the command edge
// ****************************************************************
`define SRAM_READ_LATENCY  2
`define SRAM_WRITE_LATENCY 2

// ****************************************************************
// Reset values of the pin drivers
// ****************************************************************
`define SRAM_PIN_IDLE      1'b1
`define SRAM_PIN_ACTIVE    1'b0

`endif

// ---- rtl/sram_controller.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sram_consts.svh"

module sram_controller #(
   parameter int ADDR_W = `SRAM_ADDR_W,
   parameter int HALF_W = `SRAM_HALF_W
) (
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   // Memory pins
   sram_if.controller                   bus,
   // Requests
   input  wire logic                    req_valid,
   input  wire logic                    req_write,
   input  wire logic [ADDR_W-1:0]       req_addr,
   input  wire logic [1:0]              req_half_en,
   input  wire logic [2*HALF_W-1:0]     req_wdata,
   // Answers
   output logic                         rsp_valid,
   output logic [2*HALF_W-1:0]          rsp_rdata
);
   import sram_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   cmd_type             cmd_pin;
   cmd_type             next_cmd_pin;
   cmd_type             cmd_taken;
   cmd_type             next_cmd_taken;
   cmd_type             cmd_late;
   cmd_type             next_cmd_late;
   logic [2*HALF_W-1:0] wdata_pin;
   logic [2*HALF_W-1:0] next_wdata_pin;
   logic [2*HALF_W-1:0] wdata_taken;
   logic [2*HALF_W-1:0] next_wdata_taken;
   logic [ADDR_W-1:0]   next_addr;
   logic                next_cs_n;
   logic                next_write_n;
   logic [1:0]          next_half_n;
   logic                next_oe_n;
   logic [2*HALF_W-1:0] next_dq_out;
   logic                next_dq_oe;
   logic                next_rsp_valid;
   logic [2*HALF_W-1:0] next_rsp_rdata;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_addr        = bus.addr;
      next_cs_n        = `SRAM_PIN_IDLE;
      next_write_n     = `SRAM_PIN_IDLE;
      next_half_n      = {2{`SRAM_PIN_IDLE}};
      next_cmd_pin     = CMD_IDLE;
      next_wdata_pin   = wdata_pin;
      if (req_valid) begin
         next_addr      = req_addr;
         next_cs_n      = `SRAM_PIN_ACTIVE;
         next_cmd_pin   = req_write ? CMD_WRITE : CMD_READ;
         next_write_n   = ~req_write;
         next_half_n    = req_write ? ~req_half_en : 2'b11;
         next_wdata_pin = req_wdata;
      end
      next_cmd_taken   = cmd_pin;
      next_wdata_taken = wdata_pin;
      next_cmd_late    = cmd_taken;
      // Data goes out one edge after the device took the write.
      next_dq_oe       = (cmd_taken == CMD_WRITE);
      next_dq_out      = wdata_taken;
      // Output enable is low at the read's command edge, or the device takes
      // a dummy read, and low again while the word is on the bus.
      next_oe_n        = !((req_valid && !req_write) || (cmd_taken == CMD_READ));
      next_rsp_valid   = (cmd_late == CMD_READ);
      next_rsp_rdata   = (cmd_late == CMD_READ) ? bus.dq : rsp_rdata;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmd_pin               <= CMD_IDLE;
         cmd_taken             <= CMD_IDLE;
         cmd_late              <= CMD_IDLE;
         wdata_pin             <= '0;
         wdata_taken           <= '0;
         bus.addr              <= '0;
         bus.chip_select_n     <= `SRAM_PIN_IDLE;
         bus.write_n           <= `SRAM_PIN_IDLE;
         bus.low_half_write_n  <= `SRAM_PIN_IDLE;
         bus.high_half_write_n <= `SRAM_PIN_IDLE;
         bus.clk_gate_n        <= `SRAM_PIN_ACTIVE;
         bus.output_enable_n   <= `SRAM_PIN_IDLE;
         bus.ctrl_dq_out       <= '0;
         bus.ctrl_dq_oe        <= 1'b0;
         rsp_valid             <= 1'b0;
         rsp_rdata             <= '0;
      end else begin
         cmd_pin               <= next_cmd_pin;
         cmd_taken             <= next_cmd_taken;
         cmd_late              <= next_cmd_late;
         wdata_pin             <= next_wdata_pin;
         wdata_taken           <= next_wdata_taken;
         bus.addr              <= next_addr;
         bus.chip_select_n     <= next_cs_n;
         bus.write_n           <= next_write_n;
         bus.low_half_write_n  <= next_half_n[0];
         bus.high_half_write_n <= next_half_n[1];
         bus.clk_gate_n        <= `SRAM_PIN_ACTIVE;
         bus.output_enable_n   <= next_oe_n;
         bus.ctrl_dq_out       <= next_dq_out;
         bus.ctrl_dq_oe        <= next_dq_oe;
         rsp_valid             <= next_rsp_valid;
         rsp_rdata             <= next_rsp_rdata;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/sram_device.sv ----
// How it works
// - Inputs except output enable registered on rising edge.
// - Read starts: gate low, write high, address latched.
// - Fetch between edges, drive at second edge.
// - Output enable low drives; high releases asynchronously.
// - Write data taken two edges after command.
// - Reads and writes mix with no idle cycle.
// - Array write timed internally from clock edge.
// - Continued deselect after a deselect cycle, or straight from reset.
// - 512K by 64, two halves, own write controls.
`timescale 1ns/10ps
`default_nettype none
`include "sram_consts.svh"

module sram_device #(
   parameter int ADDR_W = `SRAM_ADDR_W,
   parameter int HALF_W = `SRAM_HALF_W
) (
   // Clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rst,
   // Memory pins
   sram_if.memory                           bus,
   // Status
   output logic                             no_turnaround_mode,
   output sram_pkg::select_state_type       select_state,
   output sram_pkg::cmd_type                last_cmd
);
   import sram_pkg::*;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int HALVES = `SRAM_HALVES;
   localparam int DEPTH  = 1 << ADDR_W;
   localparam int WORD_W = HALVES * HALF_W;

   // ****************************************************************
   // Pipeline state
   // ****************************************************************
   cmd_type             cmd_first;
   cmd_type             next_cmd_first;
   cmd_type             cmd_second;
   cmd_type             next_cmd_second;
   logic [ADDR_W-1:0]   addr_first;
   logic [ADDR_W-1:0]   next_addr_first;
   logic [ADDR_W-1:0]   addr_second;
   logic [ADDR_W-1:0]   next_addr_second;
   logic [HALVES-1:0]   half_first_n;
   logic [HALVES-1:0]   next_half_first_n;
   logic [HALVES-1:0]   half_second_n;
   logic [HALVES-1:0]   next_half_second_n;
   logic [WORD_W-1:0]   read_word;
   logic [WORD_W-1:0]   next_read_word;
   logic                read_drive;
   logic                next_read_drive;
   select_state_type    next_select_state;
   cmd_type             next_last_cmd;
   logic                next_no_turnaround_mode;

   // ****************************************************************
   // Array access
   // ****************************************************************
   logic [WORD_W-1:0]   fetch_word;
   logic [HALVES-1:0]   half_write_en;
   logic                edge_live;

   // A high clock gate turns the edge into a no-op for every stage.
   assign edge_live = ~bus.clk_gate_n;

   // Each half is its own array sharing address and clock; a read that
   // meets the write landing on the same edge takes the bus data, so a
   // read right after a write to one address never sees stale contents.
   genvar h;
   generate
      for (h = 0; h < HALVES; h++) begin : g_half
         logic [HALF_W-1:0] mem [DEPTH];

         assign half_write_en[h] = edge_live && (cmd_second == CMD_WRITE)
                                   && !half_second_n[h];

         always_comb begin
            if (half_write_en[h] && (addr_second == addr_first)) begin
               fetch_word[h*HALF_W +: HALF_W] = bus.dq[h*HALF_W +: HALF_W];
            end else begin
               fetch_word[h*HALF_W +: HALF_W] = mem[addr_first];
            end
         end

         // The write pulse comes from the edge itself, no strobe is needed.
         always_ff @(posedge clk_sys) begin
            if (half_write_en[h]) begin
               mem[addr_second] <= bus.dq[h*HALF_W +: HALF_W];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_cmd_first          = cmd_first;
      next_cmd_second         = cmd_second;
      next_addr_first         = addr_first;
      next_addr_second        = addr_second;
      next_half_first_n       = half_first_n;
      next_half_second_n      = half_second_n;
      next_read_word          = read_word;
      next_read_drive         = read_drive;
      next_last_cmd           = last_cmd;
      next_no_turnaround_mode = 1'b1;
      if (edge_live) begin
         // Sample the synchronous pins on this edge.
         next_addr_first = bus.addr;
         if (bus.chip_select_n) begin
            next_cmd_first    = CMD_IDLE;
            next_half_first_n = {HALVES{1'b1}};
         end else begin
            if (!bus.write_n) begin
               next_cmd_first    = CMD_WRITE;
               next_half_first_n = {bus.high_half_write_n, bus.low_half_write_n};
            end else if (bus.output_enable_n) begin
               next_cmd_first    = CMD_DUMMY;
               next_half_first_n = {HALVES{1'b1}};
            end else begin
               next_cmd_first    = CMD_READ;
               next_half_first_n = {HALVES{1'b1}};
            end
         end
         // Second stage follows the first on every live edge, whatever the
         // mix, so a read may sit next to a write in either order.
         next_cmd_second    = cmd_first;
         next_addr_second   = addr_first;
         next_half_second_n = half_first_n;
         next_last_cmd      = cmd_first;
         if (cmd_first == CMD_READ) begin
            next_read_word  = fetch_word;
            next_read_drive = 1'b1;
         end else begin
            next_read_drive = 1'b0;
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmd_first          <= CMD_IDLE;
         cmd_second         <= CMD_IDLE;
         addr_first         <= '0;
         addr_second        <= '0;
         half_first_n       <= '1;
         half_second_n      <= '1;
         read_word          <= '0;
         read_drive         <= 1'b0;
         last_cmd           <= CMD_IDLE;
         no_turnaround_mode <= 1'b1;
      end else begin
         cmd_first          <= next_cmd_first;
         cmd_second         <= next_cmd_second;
         addr_first         <= next_addr_first;
         addr_second        <= next_addr_second;
         half_first_n       <= next_half_first_n;
         half_second_n      <= next_half_second_n;
         read_word          <= next_read_word;
         read_drive         <= next_read_drive;
         last_cmd           <= next_last_cmd;
         no_turnaround_mode <= next_no_turnaround_mode;
      end
   end

   // ****************************************************************
   // Select tracking
   // ****************************************************************
   always_comb begin
      next_select_state = select_state;
      if (edge_live) begin
         if (!bus.chip_select_n) begin
            next_select_state = SEL_ACTIVE;
         end else begin
            case (select_state)
               SEL_ACTIVE:    next_select_state = SEL_DESELECT;
               SEL_DESELECT:  next_select_state = SEL_CONTINUED;
               SEL_CONTINUED: next_select_state = SEL_CONTINUED;
               default:       next_select_state = SEL_DESELECT;
            endcase
         end
      end
   end

   // Reset keeps the pins deselected for many edges, so it already counts
   // as a stretch of continued deselect.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         select_state <= SEL_CONTINUED;
      end else begin
         select_state <= next_select_state;
      end
   end

   // ****************************************************************
   // Data pins
   // ****************************************************************
   // The enable is the one path that skips the clock: the pins must let go
   // as soon as output enable rises, so it cannot wait for an edge.
   assign bus.mem_dq_out = read_word;
   assign bus.mem_dq_oe  = read_drive & ~bus.output_enable_n;

endmodule

`default_nettype wire

// ---- rtl/sram_if.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sram_consts.svh"

interface sram_if #(
   parameter int ADDR_W = `SRAM_ADDR_W,
   parameter int HALF_W = `SRAM_HALF_W
);
   // ****************************************************************
   // Pins
   // ****************************************************************
   logic [ADDR_W-1:0]   addr;
   logic                chip_select_n;
   logic                write_n;
   logic                low_half_write_n;
   logic                high_half_write_n;
   logic                clk_gate_n;
   logic                output_enable_n;
   logic [2*HALF_W-1:0] ctrl_dq_out;
   logic                ctrl_dq_oe;
   logic [2*HALF_W-1:0] mem_dq_out;
   logic                mem_dq_oe;
   logic [2*HALF_W-1:0] dq;

   // The shared data wire takes the memory's driver while its enable is high, else the controller's.
   assign dq = mem_dq_oe ? mem_dq_out : ctrl_dq_out;

   modport memory (
      input  addr, chip_select_n, write_n, low_half_write_n, high_half_write_n,
      input  clk_gate_n, output_enable_n, dq,
      output mem_dq_out, mem_dq_oe
   );

   modport controller (
      output addr, chip_select_n, write_n, low_half_write_n, high_half_write_n,
      output clk_gate_n, output_enable_n, ctrl_dq_out, ctrl_dq_oe,
      input  dq
   );
endinterface

`default_nettype wire

// ---- rtl/sram_pkg.sv ----
`default_nettype none

package sram_pkg;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      CMD_IDLE  = 2'b00,
      CMD_READ  = 2'b01,
      CMD_DUMMY = 2'b10,
      CMD_WRITE = 2'b11
   } cmd_type;

   typedef enum logic [1:0] {
      SEL_ACTIVE    = 2'b00,
      SEL_DESELECT  = 2'b01,
      SEL_CONTINUED = 2'b10
   } select_state_type;

endpackage

`default_nettype wire

// ---- testbench/sram_props.sv ----
`timescale 1ns/10ps
`default_nettype none

module sram_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Shared pins
   input wire logic chip_select_n,
   input wire logic write_n,
   input wire logic clk_gate_n,
   input wire logic output_enable_n,
   input wire logic ctrl_dq_oe,
   input wire logic mem_dq_oe
);
   // ****************************************************************
   // Commands as the device sees them at an edge
   // ****************************************************************
   logic rd;
   logic wr;
   logic sel_rd;

   assign sel_rd = !clk_gate_n && !chip_select_n && write_n;
   assign rd     = sel_rd && !output_enable_n;
   assign wr     = !clk_gate_n && !chip_select_n && !write_n;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_read_drive;
      rd |-> ##2 (output_enable_n || mem_dq_oe);
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read data not driven");

   property p_drive_cause;
      mem_dq_oe |-> $past(rd, 2);
   endproperty
   a_drive_cause: assert property (p_drive_cause) else $error("drive without read");

   property p_oe_release;
      output_enable_n |-> !mem_dq_oe;
   endproperty
   a_oe_release: assert property (p_oe_release) else $error("drive with oe high");

   property p_read_oe;
      sel_rd |-> ##2 !output_enable_n;
   endproperty
   a_read_oe: assert property (p_read_oe) else $error("oe not low for read");

   property p_deselect;
      chip_select_n |-> ##2 !mem_dq_oe;
   endproperty
   a_deselect: assert property (p_deselect) else $error("drive after deselect");

   property p_write_data;
      wr |-> ##2 ctrl_dq_oe;
   endproperty
   a_write_data: assert property (p_write_data) else $error("write data late");

   property p_data_cause;
      ctrl_dq_oe |-> $past(wr, 2);
   endproperty
   a_data_cause: assert property (p_data_cause) else $error("data without write");

   property p_no_clash;
      !(mem_dq_oe && ctrl_dq_oe);
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("bus clash");

   property p_turn;
      rd ##1 wr |-> ##1 (output_enable_n || mem_dq_oe) ##1 ctrl_dq_oe;
   endproperty
   a_turn: assert property (p_turn) else $error("read to write turn broken");
endmodule

`default_nettype wire

// ---- testbench/test_pipelined_no_turnaround_sram.sv ----
`timescale 1ns/10ps
`default_nettype none

module test_pipelined_no_turnaround_sram;
   import sram_pkg::*;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic             clk_sys     = 1'b0;
   logic             rst         = 1'b1;
   logic             req_valid   = 1'b0;
   logic             req_write   = 1'b0;
   logic [18:0]      req_addr    = 19'h0;
   logic [1:0]       req_half_en = 2'b00;
   logic [63:0]      req_wdata   = 64'h0;
   logic             rsp_valid;
   logic [63:0]      rsp_rdata;
   logic             no_turnaround_mode;
   select_state_type select_state;
   cmd_type          last_cmd;
   int               fails       = 0;
   int               n_tests     = 0;
   int               cyc         = 0;
   logic [63:0]      model [logic [18:0]];
   logic [63:0]      exp_q [$];
   int               due_q [$];
   logic [18:0]      addrs [4]   = '{19'h0_0000, 19'h7_FFFF, 19'h2_AAAA, 19'h5_5555};

   sram_if u_sram_if ();
   sram_device u_sram_device (
      .clk_sys            (clk_sys),
      .rst                (rst),
      .bus                (u_sram_if),
      .no_turnaround_mode (no_turnaround_mode),
      .select_state       (select_state),
      .last_cmd           (last_cmd)
   );
   sram_controller u_sram_controller (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .bus         (u_sram_if),
      .req_valid   (req_valid),
      .req_write   (req_write),
      .req_addr    (req_addr),
      .req_half_en (req_half_en),
      .req_wdata   (req_wdata),
      .rsp_valid   (rsp_valid),
      .rsp_rdata   (rsp_rdata)
   );
   sram_props u_sram_props (
      .clk_sys         (clk_sys),
      .rst             (rst),
      .chip_select_n   (u_sram_if.chip_select_n),
      .write_n         (u_sram_if.write_n),
      .clk_gate_n      (u_sram_if.clk_gate_n),
      .output_enable_n (u_sram_if.output_enable_n),
      .ctrl_dq_oe      (u_sram_if.ctrl_dq_oe),
      .mem_dq_oe       (u_sram_if.mem_dq_oe)
   );

   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc <= cyc + 1;

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [63:0] pat(input logic [18:0] a);
      return 64'hFEDC_BA98_7654_3210 ^ {13'h0, a, 13'h0, a};
   endfunction

   // The model is updated at issue time, so a read right after a write expects new data.
   task automatic issue(input logic wr, input logic [18:0] a, input logic [1:0] h,
                        input logic [63:0] d);
      @(posedge clk_sys);
      #1;
      req_valid   = 1'b1;
      req_write   = wr;
      req_addr    = a;
      req_half_en = h;
      req_wdata   = d;
      if (wr) begin
         if (!model.exists(a)) model[a] = 'x;
         if (h[0]) model[a][31:0] = d[31:0];
         if (h[1]) model[a][63:32] = d[63:32];
      end else begin
         exp_q.push_back(model[a]);
         // Request, command, drive and capture edges come one after another.
         due_q.push_back(cyc + 4);
      end
   endtask

   task automatic idle();
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
   endtask

   task automatic end_case(input string name);
      int i = 0;
      idle();
      while (exp_q.size() != 0 && i < 20) begin
         @(posedge clk_sys);
         i++;
      end
      if (exp_q.size() != 0) begin
         fails++;
         finish_test();
      end
      $display("test %s done", name);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Responses are looked at mid-cycle, where the pulse has settled.
   always @(negedge clk_sys) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("spurious_rsp", 64'h0, 64'h1);
         end else begin
            chk("rdata", exp_q.pop_front(), rsp_rdata);
            chk("latency", 64'(due_q.pop_front()), 64'(cyc));
         end
      end
   end

   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      repeat (16) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      @(posedge clk_sys);
      #1;
      chk("mode", 64'h1, 64'(no_turnaround_mode));
      chk("select_state", 64'(SEL_CONTINUED), 64'(select_state));
      chk("mem_oe", 64'h0, 64'(u_sram_if.mem_dq_oe));
      $display("test reset done");
      for (int i = 0; i < 4; i++) issue(1'b1, addrs[i], 2'b11, pat(addrs[i]));
      for (int i = 0; i < 4; i++) issue(1'b0, addrs[i], 2'b00, 64'h0);
      end_case("full_words");
      issue(1'b1, 19'h1_2345, 2'b11, pat(19'h1_2345));
      for (int h = 0; h < 3; h++) begin
         issue(1'b1, 19'h1_2345, 2'(h), ~pat(19'h0) + 64'(h));
         issue(1'b0, 19'h1_2345, 2'b00, 64'h0);
      end
      end_case("halves");
      for (int i = 0; i < 4; i++) begin
         issue(1'b0, addrs[i], 2'b00, 64'h0);
         issue(1'b1, addrs[i], 2'b11, ~pat(addrs[i]));
      end
      for (int i = 0; i < 4; i++) issue(1'b0, addrs[i], 2'b00, 64'h0);
      end_case("turnaround");
      issue(1'b0, addrs[1], 2'b00, 64'h0);
      idle();
      @(posedge clk_sys);
      #1;
      chk("select_state", 64'(SEL_ACTIVE), 64'(select_state));
      @(posedge clk_sys);
      #1;
      chk("select_state", 64'(SEL_DESELECT), 64'(select_state));
      chk("last_cmd", 64'(CMD_READ), 64'(last_cmd));
      @(posedge clk_sys);
      #1;
      chk("select_state", 64'(SEL_CONTINUED), 64'(select_state));
      chk("last_cmd", 64'(CMD_IDLE), 64'(last_cmd));
      end_case("deselect");
      finish_test();
   end
endmodule

`default_nettype wire
